// ===== hw/decim_cfg_pkg.sv
/*
  Shared constants for the decimation, gain trim and output width configuration.
  Assumes byte-wide registers reached through the serial control port.
*/
package decim_cfg_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int SAMP_W = 16;
  localparam int TRIM_W = 14;
  localparam int TRIM_FRAC = 10;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [14:0] OFS_SECOND_STAGE = 15'h011A;
  localparam logic [14:0] OFS_EFF_BURST = 15'h011B;
  localparam logic [14:0] OFS_TRIM0_LOW = 15'h0152;
  localparam logic [14:0] OFS_TRIM0_MID = 15'h0153;
  localparam logic [14:0] OFS_TRIM0_HIGH = 15'h0154;
  localparam logic [14:0] OFS_TRIM1_LOW = 15'h0155;
  localparam logic [14:0] OFS_TRIM1_MID = 15'h0156;
  localparam logic [14:0] OFS_TRIM1_HIGH = 15'h0157;
  localparam logic [14:0] OFS_TRIM2_LOW = 15'h0158;
  localparam logic [14:0] OFS_TRIM2_MID = 15'h0159;
  localparam logic [14:0] OFS_TRIM2_HIGH = 15'h0170;
  localparam logic [14:0] OFS_OUT_WIDTH = 15'h0189;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int TRIM_MID_LSB = 8;
  localparam int TRIM_HIGH_LSB = 10;
  localparam int DITHER_BIT = 5;
  localparam int SPARE_BIT = 4;
  localparam int RW_BIT = 15;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] RST_SECOND_STAGE = 4'h0;
  localparam logic [7:0] RST_EFF_BURST = 8'h10;
  localparam logic [7:0] RST_TRIM0_LOW = 8'h07;
  localparam logic [7:0] RST_TRIM1_LOW = 8'h20;
  localparam logic [7:0] RST_TRIM2_LOW = 8'h4A;
  localparam logic [1:0] RST_TRIM_MID = 2'h0;
  localparam logic [3:0] RST_TRIM_HIGH = 4'h1;
  localparam logic [3:0] RST_OUT_WIDTH = 4'h0;
  // ---------------------------------------------------------------
  // second stage rate codes, output width limits, dither seed and serial frame lengths
  // ---------------------------------------------------------------
  localparam logic [3:0] RATE_DIV10 = 4'h9;
  localparam logic [3:0] WIDTH_CODE_MAX = 4'h8;
  localparam logic [4:0] WIDTH_FULL = 5'h10;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  localparam int SPI_FRAME_BITS = 24;
  localparam int SPI_INSTR_BITS = 16;
endpackage

// ===== hw/serial_port_slave.sv
/*
  Serial control port slave: 16-bit instruction (read flag, 15-bit address)
  then one data byte, msb first, data taken on rising clock, driven on falling.
  Assumes the serial clock is well below a quarter of sys_clk.
*/
`timescale 1ns/100ps
module serial_port_slave
  import decim_cfg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  output logic [14:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  input wire logic [7:0] reg_rdata
);
  logic [2:0] sync1_ff, nxt_sync1, sync2_ff, nxt_sync2;
  logic sclk_prev_ff, nxt_sclk_prev;
  logic [4:0] cnt_ff, nxt_cnt;
  logic [15:0] instr_ff, nxt_instr;
  logic [7:0] shift_ff, nxt_shift;
  logic sdo_ff, nxt_sdo;
  logic wr_ff, nxt_wr;
  logic cs_act, rise, fall;

  assign cs_act = ~sync2_ff[2];
  assign rise = sync2_ff[1] & ~sclk_prev_ff;
  assign fall = ~sync2_ff[1] & sclk_prev_ff;
  assign reg_addr = instr_ff[14:0];
  assign reg_wdata = shift_ff;
  assign reg_wr = wr_ff;
  assign spi_sdo = sdo_ff;
  assign spi_sdo_oe = cs_act & instr_ff[RW_BIT] & (cnt_ff >= 5'(SPI_INSTR_BITS));

  always_comb
  begin
    nxt_sync1 = {spi_cs_n, spi_sclk, spi_sdi};
    nxt_sync2 = sync1_ff;
    nxt_sclk_prev = sync2_ff[1];
    nxt_cnt = cnt_ff;
    nxt_instr = instr_ff;
    nxt_shift = shift_ff;
    nxt_sdo = sdo_ff;
    nxt_wr = 1'b0;
    if (!cs_act)
    begin
      nxt_cnt = '0;
      nxt_sdo = 1'b0;
    end
    else if (rise && cnt_ff < 5'(SPI_INSTR_BITS))
    begin
      nxt_instr = {instr_ff[14:0], sync2_ff[0]};
      nxt_cnt = cnt_ff + 5'd1;
    end
    else if (rise && cnt_ff < 5'(SPI_FRAME_BITS))
    begin
      nxt_cnt = cnt_ff + 5'd1;
      if (!instr_ff[RW_BIT])
      begin
        nxt_shift = {shift_ff[6:0], sync2_ff[0]};
        nxt_wr = (cnt_ff == 5'(SPI_FRAME_BITS - 1));
      end
    end
    else if (fall && cnt_ff == 5'(SPI_INSTR_BITS) && instr_ff[RW_BIT])
    begin
      nxt_shift = {reg_rdata[6:0], 1'b0};
      nxt_sdo = reg_rdata[7];
    end
    else if (fall && cnt_ff > 5'(SPI_INSTR_BITS) && instr_ff[RW_BIT])
    begin
      nxt_sdo = shift_ff[7];
      nxt_shift = {shift_ff[6:0], 1'b0};
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      sync1_ff <= 3'h7;
      sync2_ff <= 3'h7;
      sclk_prev_ff <= 1'b1;
      cnt_ff <= '0;
      instr_ff <= '0;
      shift_ff <= '0;
      sdo_ff <= 1'b0;
      wr_ff <= 1'b0;
    end
    else
    begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      sclk_prev_ff <= nxt_sclk_prev;
      cnt_ff <= nxt_cnt;
      instr_ff <= nxt_instr;
      shift_ff <= nxt_shift;
      sdo_ff <= nxt_sdo;
      wr_ff <= nxt_wr;
    end
  end
endmodule

// ===== hw/second_stage_path.sv
/*
  Second stage: source select, comb gain trim on comb samples, and keep-one-of-N
  decimation. Assumes samples and settings arrive on sys_clk.
*/
`timescale 1ns/100ps
module second_stage_path
  import decim_cfg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [15:0] comb_sample,
  input wire logic [15:0] raw_sample,
  input wire logic [1:0] sample_group,
  input wire logic sample_valid,
  input wire logic raw_source,
  input wire logic [7:0] decim_factor,
  input wire logic [41:0] trims,
  output logic [15:0] dec_sample,
  output logic dec_valid
);
  logic [7:0] cnt_ff, nxt_cnt;
  logic [15:0] samp_ff, nxt_samp;
  logic valid_ff, nxt_valid;
  logic [13:0] trim;
  logic [15:0] src;

  // signed sample times unsigned 4.10 trim, saturated to 16 bits
  function automatic logic [15:0] apply_trim(input logic [15:0] s, input logic [13:0] g);
    logic signed [31:0] p;
    p = 32'(signed'(s)) * 32'(signed'({2'b00, g}));
    p = p >>> TRIM_FRAC;
    if (p > 32'sd32767)
      apply_trim = 16'h7FFF;
    else if (p < -32'sd32768)
      apply_trim = 16'h8000;
    else
      apply_trim = p[15:0];
  endfunction

  assign trim = (sample_group == 2'd1) ? trims[27:14] :
                (sample_group == 2'd2) ? trims[41:28] : trims[13:0];
  assign src = raw_source ? raw_sample : apply_trim(comb_sample, trim);
  assign dec_sample = samp_ff;
  assign dec_valid = valid_ff;

  always_comb
  begin
    nxt_cnt = cnt_ff;
    nxt_samp = samp_ff;
    nxt_valid = 1'b0;
    if (sample_valid)
    begin
      if (cnt_ff + 8'd1 >= decim_factor)
      begin
        nxt_cnt = '0;
        nxt_samp = src;
        nxt_valid = 1'b1;
      end
      else
        nxt_cnt = cnt_ff + 8'd1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      cnt_ff <= '0;
      samp_ff <= '0;
      valid_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      samp_ff <= nxt_samp;
      valid_ff <= nxt_valid;
    end
  end
endmodule

// ===== hw/decimator_gain_resolution_cfg.sv
/*
  Decimation rate, burst ratio readback, comb gain trims and output word width
  with dither, reached through the serial control port.
  Assumes serial pins are asynchronous to sys_clk and samples arrive on sys_clk.
*/
// Functional notes
// - codes 0111/1010/1011/1111 divide by 24/20/40/60
// - code 1001 divides by 10, comb source only
// - read-only burst ratio, reset 0x10
// - trims are unsigned 4.10 over three bytes
// - three trims with their own reset values
// - third trim top nibble at 0x170 low
// - source bit: 1 raw, 0 comb output
// - 0000 bypass, 0001/0010 by 4, 0011 16, 0110 12
// - burst bit picks averaging path, else second stage
`timescale 1ns/100ps
module decimator_gain_resolution_cfg
  import decim_cfg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  input wire logic burst_mode_on,
  input wire logic second_stage_raw_source,
  input wire logic [7:0] burst_ratio_in,
  input wire logic [15:0] comb_sample,
  input wire logic [15:0] raw_sample,
  input wire logic [1:0] sample_group,
  input wire logic sample_valid,
  output logic [15:0] out_sample,
  output logic out_valid,
  output logic rate_code_invalid,
  output logic [13:0] comb_gain_trim_a,
  output logic [13:0] comb_gain_trim_b,
  output logic [13:0] comb_gain_trim_c
);
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [14:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic [7:0] reg_rdata;
  logic [3:0] second_stage_rate_ff, nxt_second_stage_rate;
  logic [7:0] effective_burst_ratio_ff, nxt_effective_burst_ratio;
  logic [13:0] trim_a_ff, nxt_trim_a;
  logic [13:0] trim_b_ff, nxt_trim_b;
  logic [13:0] trim_c_ff, nxt_trim_c;
  logic [3:0] output_word_width_ff, nxt_output_word_width;
  logic output_dither_on_ff, nxt_output_dither_on;
  logic spare_bit_ff, nxt_spare_bit;
  logic [7:0] j_factor;
  logic [7:0] decim_factor;
  logic [15:0] dec_sample;
  logic dec_valid;
  logic [15:0] lfsr_ff, nxt_lfsr;
  logic [15:0] out_sample_ff, nxt_out_sample;
  logic out_valid_ff, nxt_out_valid;

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  // second stage rate code to division factor; 0 marks an unusable code
  function automatic logic [7:0] rate_factor(input logic [3:0] code, input logic raw);
    case (code)
      4'h0: rate_factor = 8'd1;
      4'h1: rate_factor = 8'd4;
      4'h2: rate_factor = 8'd4;
      4'h3: rate_factor = 8'd16;
      4'h6: rate_factor = 8'd12;
      4'h7: rate_factor = 8'd24;
      4'h9: rate_factor = raw ? 8'd0 : 8'd10;
      4'hA: rate_factor = 8'd20;
      4'hB: rate_factor = 8'd40;
      4'hF: rate_factor = 8'd60;
      default: rate_factor = 8'd0;
    endcase
  endfunction

  // number of dropped low bits for a width code, clamped at 8-bit output
  function automatic logic [3:0] drop_bits(input logic [3:0] code);
    if (code > WIDTH_CODE_MAX)
      drop_bits = WIDTH_CODE_MAX;
    else
      drop_bits = code;
  endfunction

  // mask keeping the upper (16 - drop) bits
  function automatic logic [15:0] keep_mask(input logic [3:0] drop);
    keep_mask = 16'hFFFF << drop;
  endfunction

  // one byte lane of a trim value as read back, reserved bits zero
  function automatic logic [7:0] trim_byte(input logic [13:0] t, input logic [1:0] lane);
    case (lane)
      2'd0: trim_byte = t[7:0];
      2'd1: trim_byte = {6'h00, t[9:8]};
      default: trim_byte = {4'h0, t[13:10]};
    endcase
  endfunction

  // ---------------------------------------------------------------
  // serial control port
  // ---------------------------------------------------------------
  serial_port_slave u_port
  (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .spi_cs_n(spi_cs_n),
    .spi_sclk(spi_sclk),
    .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo),
    .spi_sdo_oe(spi_sdo_oe),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rdata(reg_rdata)
  );

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_second_stage_rate = second_stage_rate_ff;
    nxt_trim_a = trim_a_ff;
    nxt_trim_b = trim_b_ff;
    nxt_trim_c = trim_c_ff;
    nxt_output_word_width = output_word_width_ff;
    nxt_output_dither_on = output_dither_on_ff;
    nxt_spare_bit = spare_bit_ff;
    // burst ratio follows the averaging block while burst mode is on
    if (burst_mode_on)
      nxt_effective_burst_ratio = burst_ratio_in;
    else
      nxt_effective_burst_ratio = effective_burst_ratio_ff;
    if (reg_wr)
    begin
      case (reg_addr)
        OFS_SECOND_STAGE: nxt_second_stage_rate = reg_wdata[3:0];
        OFS_TRIM0_LOW: nxt_trim_a[7:0] = reg_wdata;
        OFS_TRIM0_MID: nxt_trim_a[9:8] = reg_wdata[1:0];
        OFS_TRIM0_HIGH: nxt_trim_a[13:10] = reg_wdata[3:0];
        OFS_TRIM1_LOW: nxt_trim_b[7:0] = reg_wdata;
        OFS_TRIM1_MID: nxt_trim_b[9:8] = reg_wdata[1:0];
        OFS_TRIM1_HIGH: nxt_trim_b[13:10] = reg_wdata[3:0];
        OFS_TRIM2_LOW: nxt_trim_c[7:0] = reg_wdata;
        OFS_TRIM2_MID: nxt_trim_c[9:8] = reg_wdata[1:0];
        OFS_TRIM2_HIGH: nxt_trim_c[13:10] = reg_wdata[3:0];
        OFS_OUT_WIDTH:
        begin
          nxt_output_word_width = reg_wdata[3:0];
          nxt_spare_bit = reg_wdata[SPARE_BIT];
          nxt_output_dither_on = reg_wdata[DITHER_BIT];
        end
        default: nxt_spare_bit = spare_bit_ff;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      second_stage_rate_ff <= RST_SECOND_STAGE;
      effective_burst_ratio_ff <= RST_EFF_BURST;
      trim_a_ff <= {RST_TRIM_HIGH, RST_TRIM_MID, RST_TRIM0_LOW};
      trim_b_ff <= {RST_TRIM_HIGH, RST_TRIM_MID, RST_TRIM1_LOW};
      trim_c_ff <= {RST_TRIM_HIGH, RST_TRIM_MID, RST_TRIM2_LOW};
      output_word_width_ff <= RST_OUT_WIDTH;
      output_dither_on_ff <= 1'b0;
      spare_bit_ff <= 1'b0;
    end
    else
    begin
      second_stage_rate_ff <= nxt_second_stage_rate;
      effective_burst_ratio_ff <= nxt_effective_burst_ratio;
      trim_a_ff <= nxt_trim_a;
      trim_b_ff <= nxt_trim_b;
      trim_c_ff <= nxt_trim_c;
      output_word_width_ff <= nxt_output_word_width;
      output_dither_on_ff <= nxt_output_dither_on;
      spare_bit_ff <= nxt_spare_bit;
    end
  end

  // ---------------------------------------------------------------
  // register reads
  // ---------------------------------------------------------------
  always_comb
  begin
    case (reg_addr)
      OFS_SECOND_STAGE: reg_rdata = {4'h0, second_stage_rate_ff};
      OFS_EFF_BURST: reg_rdata = effective_burst_ratio_ff;
      OFS_TRIM0_LOW: reg_rdata = trim_byte(trim_a_ff, 2'd0);
      OFS_TRIM0_MID: reg_rdata = trim_byte(trim_a_ff, 2'd1);
      OFS_TRIM0_HIGH: reg_rdata = trim_byte(trim_a_ff, 2'd2);
      OFS_TRIM1_LOW: reg_rdata = trim_byte(trim_b_ff, 2'd0);
      OFS_TRIM1_MID: reg_rdata = trim_byte(trim_b_ff, 2'd1);
      OFS_TRIM1_HIGH: reg_rdata = trim_byte(trim_b_ff, 2'd2);
      OFS_TRIM2_LOW: reg_rdata = trim_byte(trim_c_ff, 2'd0);
      OFS_TRIM2_MID: reg_rdata = trim_byte(trim_c_ff, 2'd1);
      OFS_TRIM2_HIGH: reg_rdata = trim_byte(trim_c_ff, 2'd2);
      OFS_OUT_WIDTH:
        reg_rdata = {2'b00, output_dither_on_ff, spare_bit_ff, output_word_width_ff};
      default: reg_rdata = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // rate selection
  // ---------------------------------------------------------------
  assign j_factor = rate_factor(second_stage_rate_ff, second_stage_raw_source);
  // an unusable code falls back to bypass and is flagged
  assign rate_code_invalid = ~burst_mode_on & (j_factor == 8'd0);
  // a zero burst ratio is taken as divide by one
  always_comb
  begin
    if (burst_mode_on && effective_burst_ratio_ff == 8'd0)
      decim_factor = 8'd1;
    else if (burst_mode_on)
      decim_factor = effective_burst_ratio_ff;
    else if (j_factor == 8'd0)
      decim_factor = 8'd1;
    else
      decim_factor = j_factor;
  end

  assign comb_gain_trim_a = trim_a_ff;
  assign comb_gain_trim_b = trim_b_ff;
  assign comb_gain_trim_c = trim_c_ff;

  // ---------------------------------------------------------------
  // source select, trim and decimation
  // ---------------------------------------------------------------
  second_stage_path u_path
  (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .comb_sample(comb_sample),
    .raw_sample(raw_sample),
    .sample_group(sample_group),
    .sample_valid(sample_valid),
    .raw_source(second_stage_raw_source & ~burst_mode_on),
    .decim_factor(decim_factor),
    .trims({trim_c_ff, trim_b_ff, trim_a_ff}),
    .dec_sample(dec_sample),
    .dec_valid(dec_valid)
  );

  // ---------------------------------------------------------------
  // output word width and dither
  // ---------------------------------------------------------------
  always_comb
  begin
    logic [3:0] drop;
    logic [15:0] mask;
    logic signed [16:0] sum;
    drop = drop_bits(output_word_width_ff);
    mask = keep_mask(drop);
    sum = 17'(signed'(dec_sample));
    nxt_lfsr = lfsr_ff;
    nxt_out_sample = out_sample_ff;
    nxt_out_valid = dec_valid;
    if (dec_valid)
    begin
      // lfsr steps once per output sample, so the noise is repeatable
      nxt_lfsr = {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
      // dither adds noise below the kept lsb before truncation
      if (output_dither_on_ff)
        sum = sum + 17'(lfsr_ff & ~mask);
      if (sum > 17'sd32767)
        sum = 17'sd32767;
      nxt_out_sample = sum[15:0] & mask;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      lfsr_ff <= LFSR_SEED;
      out_sample_ff <= '0;
      out_valid_ff <= 1'b0;
    end
    else
    begin
      lfsr_ff <= nxt_lfsr;
      out_sample_ff <= nxt_out_sample;
      out_valid_ff <= nxt_out_valid;
    end
  end

  assign out_sample = out_sample_ff;
  assign out_valid = out_valid_ff;
endmodule

// ===== tb/decim_cfg_checker.sv
/*
  Port checker for the decimation and gain trim configuration block.
  Assumes it is bound to the top module and sees its ports only.
*/
`timescale 1ns/100ps
module decim_cfg_checker
  import decim_cfg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic spi_cs_n,
  input wire logic spi_sdo_oe,
  input wire logic burst_mode_on,
  input wire logic sample_valid,
  input wire logic [15:0] out_sample,
  input wire logic out_valid,
  input wire logic rate_code_invalid,
  input wire logic [13:0] comb_gain_trim_a,
  input wire logic [13:0] comb_gain_trim_b,
  input wire logic [13:0] comb_gain_trim_c
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  a_trim_reset_vals: assert property (
    $rose(rst_n) |-> comb_gain_trim_a == 14'h0407 && comb_gain_trim_b == 14'h0420
      && comb_gain_trim_c == 14'h044a)
    else $error("trim reset value wrong");
  a_burst_no_flag: assert property (
    burst_mode_on |-> !rate_code_invalid)
    else $error("rate flag raised in burst mode");
  a_out_cause: assert property (
    out_valid |-> $past(sample_valid, 2))
    else $error("output without a sample two cycles before");
  a_out_hold: assert property (
    !out_valid |-> $stable(out_sample))
    else $error("output sample moved without valid");
  a_reset_quiet: assert property (
    $rose(rst_n) |-> !out_valid && !spi_sdo_oe && out_sample == 16'h0000)
    else $error("outputs not quiet after reset");
  a_oe_rise_sel: assert property (
    $rose(spi_sdo_oe) |-> !spi_cs_n)
    else $error("read driver on while not selected");
  a_oe_past_sel: assert property (
    spi_sdo_oe |-> !$past(spi_cs_n, 4))
    else $error("read driver held after deselect");
  a_trim_idle_hold: assert property (
    spi_cs_n [*6] |-> $stable(comb_gain_trim_a) && $stable(comb_gain_trim_b)
      && $stable(comb_gain_trim_c))
    else $error("trim changed with port idle");
endmodule

bind decimator_gain_resolution_cfg decim_cfg_checker i_decim_cfg_checker (
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .spi_cs_n(spi_cs_n),
  .spi_sdo_oe(spi_sdo_oe),
  .burst_mode_on(burst_mode_on),
  .sample_valid(sample_valid),
  .out_sample(out_sample),
  .out_valid(out_valid),
  .rate_code_invalid(rate_code_invalid),
  .comb_gain_trim_a(comb_gain_trim_a),
  .comb_gain_trim_b(comb_gain_trim_b),
  .comb_gain_trim_c(comb_gain_trim_c)
);

// ===== tb/decimator_gain_resolution_cfg_bench.sv
/*
  Self-checking bench: serial register access, trims, rate codes, burst and width.
  Assumes the package constants and the hand-over latencies of the design.
*/
`timescale 1ns/100ps
module decimator_gain_resolution_cfg_bench
  import decim_cfg_pkg::*;
;
  logic sys_clk, rst_n, spi_cs_n, spi_sclk, spi_sdi, spi_sdo, spi_sdo_oe;
  logic burst_mode_on, raw_src, sample_valid, out_valid, rate_code_invalid;
  logic [7:0] burst_ratio_in, ratio;
  logic [15:0] comb_sample, raw_sample, out_sample;
  logic [1:0] sample_group;
  logic [13:0] trim_a, trim_b, trim_c;
  logic [13:0] trims [3];
  logic [3:0] width_code;
  logic [7:0] d;
  logic [15:0] raw_keep;
  int fails, comparisons;
  logic [14:0] regs [12] = '{OFS_SECOND_STAGE, OFS_EFF_BURST, OFS_TRIM0_LOW, OFS_TRIM0_MID,
    OFS_TRIM0_HIGH, OFS_TRIM1_LOW, OFS_TRIM1_MID, OFS_TRIM1_HIGH, OFS_TRIM2_LOW,
    OFS_TRIM2_MID, OFS_TRIM2_HIGH, OFS_OUT_WIDTH};
  logic [7:0] rstv [12] = '{8'h00, 8'h10, 8'h07, 8'h00, 8'h01, 8'h20, 8'h00, 8'h01,
    8'h4a, 8'h00, 8'h01, 8'h00};
  logic [7:0] mask [12] = '{8'h0f, 8'h00, 8'hff, 8'h03, 8'h0f, 8'hff, 8'h03, 8'h0f,
    8'hff, 8'h03, 8'h0f, 8'h3f};
  logic [3:0] codes [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'h9, 4'ha, 4'hb, 4'hf};
  int facts [10] = '{1, 4, 4, 16, 12, 24, 10, 20, 40, 60};
  logic [3:0] bad [6] = '{4'h4, 4'h5, 4'h8, 4'hc, 4'hd, 4'he};

  decimator_gain_resolution_cfg i_decimator_gain_resolution_cfg (
    .sys_clk(sys_clk), .rst_n(rst_n), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
    .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
    .burst_mode_on(burst_mode_on), .second_stage_raw_source(raw_src),
    .burst_ratio_in(burst_ratio_in), .comb_sample(comb_sample), .raw_sample(raw_sample),
    .sample_group(sample_group), .sample_valid(sample_valid), .out_sample(out_sample),
    .out_valid(out_valid), .rate_code_invalid(rate_code_invalid),
    .comb_gain_trim_a(trim_a), .comb_gain_trim_b(trim_b), .comb_gain_trim_c(trim_c)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic end_sim();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic do_reset();
    rst_n = 1'b0;
    cyc(5);
    rst_n = 1'b1;
    cyc(4);
    trims = '{14'h0407, 14'h0420, 14'h044a};
    width_code = 4'h0;
  endtask

  // one frame: read flag, 15-bit address, one data byte, msb first
  task automatic spi(bit rd, logic [14:0] a, logic [7:0] wd, output logic [7:0] rdat);
    logic [23:0] frame;
    frame = {rd, a, wd};
    rdat = 8'h00;
    spi_cs_n = 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      spi_sdi = frame[i];
      spi_sclk = 1'b0;
      cyc(6);
      if (i < 8)
        rdat[i] = spi_sdo;
      spi_sclk = 1'b1;
      cyc(6);
    end
    spi_sclk = 1'b0;
    spi_sdi = ~spi_sdi;
    cyc(6);
    spi_cs_n = 1'b1;
    cyc(8);
  endtask

  task automatic wr(logic [14:0] a, logic [7:0] wd);
    logic [7:0] x;
    spi(1'b0, a, wd, x);
  endtask

  task automatic rd_chk(logic [14:0] a, logic [7:0] e);
    logic [7:0] x;
    spi(1'b1, a, 8'h00, x);
    chk($sformatf("register %h", a), {8'h00, e}, {8'h00, x});
  endtask

  task automatic chk_trims();
    chk("trim a", {2'b00, trims[0]}, {2'b00, trim_a});
    chk("trim b", {2'b00, trims[1]}, {2'b00, trim_b});
    chk("trim c", {2'b00, trims[2]}, {2'b00, trim_c});
  endtask

  function automatic logic [15:0] exp_out(logic [15:0] s, logic [13:0] t, bit raw,
    logic [3:0] wc);
    longint p;
    int sh;
    p = raw ? longint'($signed(s)) : (longint'($signed(s)) * longint'(t)) >>> 10;
    if (p > 32767)
      p = 32767;
    if (p < -32768)
      p = -32768;
    sh = (wc > 4'h8) ? 8 : int'(wc);
    return 16'(p) & (16'hffff << sh);
  endfunction

  // back-to-back samples; checks every output but that of the last sample, and the first output spacing
  task automatic stream(int n, int gap);
    logic [15:0] q [$];
    bit sel;
    int last;
    int got;
    last = -1;
    got = 0;
    for (int i = 0; i < n; i++)
    begin
      comb_sample = 16'($urandom);
      raw_sample = 16'($urandom) & raw_keep;
      sample_group = 2'($urandom);
      sample_valid = 1'b1;
      sel = raw_src && !burst_mode_on;
      q.push_back(exp_out(sel ? raw_sample : comb_sample,
        trims[(sample_group == 2'h3) ? 2'h0 : sample_group], sel, width_code));
      cyc(1);
      if (i >= 1 && out_valid === 1'b1)
      begin
        chk("out_sample", q[i - 1], out_sample);
        if (last >= 0 && got == 0 && gap > 0)
        begin
          chk("decimation gap", 16'(gap), 16'(i - last));
          got = 1;
        end
        last = i;
      end
    end
    sample_valid = 1'b0;
    if (gap > 0 && got == 0)
    begin
      fails++;
      $display("Error decimation gap expected %0d seen none", gap);
      end_sim();
    end
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_sdi = 1'b0;
    burst_mode_on = 1'b0;
    raw_src = 1'b0;
    burst_ratio_in = 8'h00;
    comb_sample = 16'h0000;
    raw_sample = 16'h0000;
    raw_keep = 16'hffff;
    sample_group = 2'h0;
    sample_valid = 1'b0;
    fails = 0;
    comparisons = 0;
    void'($urandom(32'hed13_0c58));
    do_reset();
    chk_trims();
    for (int k = 0; k < 12; k++)
      rd_chk(regs[k], rstv[k]);
    $display("test reset values done");
    for (int k = 0; k < 12; k++)
    begin
      d = 8'($urandom);
      wr(regs[k], d);
      rd_chk(regs[k], (d & mask[k]) | (rstv[k] & ~mask[k]));
      if (k >= 2 && k <= 10)
        case ((k - 2) % 3)
          0: trims[(k - 2) / 3][7:0] = d;
          1: trims[(k - 2) / 3][9:8] = d[1:0];
          default: trims[(k - 2) / 3][13:10] = d[3:0];
        endcase
    end
    chk_trims();
    rd_chk(15'h0100, 8'h00);
    $display("test register access done");
    wr(OFS_SECOND_STAGE, 8'h00);
    for (int r = 0; r < 6; r++)
    begin
      width_code = (r == 0) ? 4'h8 : 4'($urandom);
      raw_src = r[0];
      wr(OFS_OUT_WIDTH, {4'h0, width_code});
      stream(30, 1);
    end
    // zero low raw byte keeps the dithered output equal to plain truncation
    width_code = 4'h8;
    raw_src = 1'b1;
    raw_keep = 16'hff00;
    wr(OFS_OUT_WIDTH, 8'h28);
    stream(20, 0);
    chk("dither low bits", 16'h0000, {8'h00, out_sample[7:0]});
    raw_keep = 16'hffff;
    wr(OFS_OUT_WIDTH, 8'h00);
    width_code = 4'h0;
    raw_src = 1'b0;
    $display("test width and trim done");
    for (int k = 0; k < 10; k++)
    begin
      wr(OFS_SECOND_STAGE, {4'h0, codes[k]});
      chk("rate flag", 16'h0000, {15'h0000, rate_code_invalid});
      stream(2 * facts[k] + 8, facts[k]);
    end
    for (int k = 0; k < 6; k++)
    begin
      wr(OFS_SECOND_STAGE, {4'h0, bad[k]});
      chk("rate flag", 16'h0001, {15'h0000, rate_code_invalid});
    end
    raw_src = 1'b1;
    wr(OFS_SECOND_STAGE, 8'h03);
    chk("rate flag", 16'h0000, {15'h0000, rate_code_invalid});
    stream(40, 16);
    $display("test rate codes done");
    ratio = 8'h05 + 8'($urandom % 8);
    burst_ratio_in = ratio;
    burst_mode_on = 1'b1;
    wr(OFS_SECOND_STAGE, 8'h04);
    chk("rate flag", 16'h0000, {15'h0000, rate_code_invalid});
    rd_chk(OFS_EFF_BURST, ratio);
    stream(2 * int'(ratio) + 8, int'(ratio));
    burst_mode_on = 1'b0;
    burst_ratio_in = ~ratio;
    rd_chk(OFS_EFF_BURST, ratio);
    chk("rate flag", 16'h0001, {15'h0000, rate_code_invalid});
    $display("test burst done");
    do_reset();
    chk_trims();
    $display("test second reset done");
    end_sim();
  end
endmodule
